// File: stc_classifier.v
/*
  Security transition and fault classifier. Checks each flow change for a
  legal security state move, runs the Secure-to-Non-secure call and return
  sequence, and sorts fault causes into five handlers with sticky flags.
  Assumes all inputs come from logic on clk_sys, event inputs are one-cycle
  pulses, and the Secure stack answers a pop request some cycles later.
*/
`timescale 1ns/100ps
`default_nettype none
`include "stc_defs.vh"
module stc_classifier (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Flow change from the execute pipeline
  input wire br_valid,
  input wire br_sequential,
  input wire br_ns_branch,
  input wire br_ns_call,
  input wire [31:0] br_target,
  input wire br_tgt_secure,
  input wire br_tgt_callable,
  input wire br_tgt_gateway,
  input wire [31:0] br_return_addr,
  input wire [31:0] cur_status_word,
  // Writes of a loaded or register value to the PC
  input wire pcw_valid,
  input wire pcw_pop_multi,
  input wire pcw_load,
  input wire pcw_reg_branch,
  input wire [31:0] pcw_value,
  // Secure stack pop answer
  input wire stk_pop_valid,
  input wire [31:0] stk_pop_pc,
  input wire [31:0] stk_pop_status,
  // Raw fault causes
  input wire vec_read_bus_err,
  input wire fault_escalated,
  input wire [4:0] protect_mismatch,
  input wire xn_fetch,
  input wire [5:0] bus_err,
  input wire [6:0] usage_err,
  input wire [6:0] secure_err,
  // Flag clears, one bit per flag
  input wire [1:0] clr_severe,
  input wire [4:0] clr_protect,
  input wire [5:0] clr_bus,
  input wire [6:0] clr_usage,
  input wire [6:0] clr_secure,
  // Security state and call sequence outputs
  output reg secure_state_q,
  output reg lr_load_q,
  output reg [31:0] lr_value_q,
  output reg stk_push_q,
  output reg [31:0] stk_push_addr_q,
  output reg [31:0] stk_push_status_q,
  output reg stk_pop_req_q,
  output reg restore_valid_q,
  output reg [31:0] restore_pc_q,
  output reg [31:0] restore_status_q,
  output reg exception_return_marker_q,
  // Fault classification outputs
  output reg [`STC_NUM_H-1:0] fault_take_q,
  output reg [1:0] severe_flags_q,
  output reg [4:0] protect_flags_q,
  output reg [5:0] bus_flags_q,
  output reg [6:0] usage_flags_q,
  output reg [6:0] secure_flags_q
);
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_POP = 2'h1;

  reg [1:0] state_q;
  reg [1:0] state_d;
  wire chk_next_secure;
  wire chk_bad_tran;
  wire chk_bad_entry;
  wire pcw_any;
  wire is_exc_ret;
  wire is_fn_ret;
  wire [6:0] sec_set;
  wire [4:0] prot_set;
  wire [1:0] sev_set;

  // Sticky flag update where a fresh event beats a clear in the same cycle.
  function [6:0] sticky;
    input [6:0] cur;
    input [6:0] set;
    input [6:0] clr;
    begin
      sticky = set | (cur & ~clr);
    end
  endfunction

  stc_target_check u_check (
    .cur_secure(secure_state_q),
    .tgt_secure(br_tgt_secure),
    .tgt_callable(br_tgt_callable),
    .tgt_lsb(br_target[0]),
    .tgt_has_gateway(br_tgt_gateway),
    .is_ns_branch(br_ns_branch),
    .is_ns_call(br_ns_call),
    .is_sequential(br_sequential),
    .next_secure(chk_next_secure),
    .bad_transition(chk_bad_tran),
    .bad_entry(chk_bad_entry)
  );

  assign pcw_any = pcw_valid && (pcw_pop_multi || pcw_load || pcw_reg_branch);
  // The prefix test comes first so an exception return is never a function return.
  assign is_exc_ret = pcw_any &&
    (pcw_value[`STC_EXCRET_HI:`STC_EXCRET_LO] == `STC_EXCRET_PREFIX);
  assign is_fn_ret = pcw_any && !is_exc_ret && !secure_state_q &&
    (pcw_value == `STC_FNRET_MARKER) && (state_q == ST_RUN);

  // Gateway and transition causes join the externally reported ones.
  assign sec_set = secure_err |
    ({6'h00, br_valid & chk_bad_entry} << `STC_SF_ENTRY) |
    ({6'h00, br_valid & chk_bad_tran} << `STC_SF_INVALID_TRANSITION_FLAG);
  // Execute-never fetch does not depend on a protection unit being present.
  assign prot_set = protect_mismatch | ({4'h0, xn_fetch} << `STC_MF_INSTR);
  assign sev_set = ({1'b0, vec_read_bus_err} << `STC_HF_VECTOR) |
    ({1'b0, fault_escalated} << `STC_HF_ESCAL);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (is_fn_ret) begin
          state_d = ST_POP;
        end
      end
      ST_POP: begin
        if (stk_pop_valid) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ST_RUN;
      secure_state_q <= `STC_RST_SECURE;
      lr_load_q <= 1'b0;
      lr_value_q <= 32'h0000_0000;
      stk_push_q <= 1'b0;
      stk_push_addr_q <= 32'h0000_0000;
      stk_push_status_q <= 32'h0000_0000;
      stk_pop_req_q <= 1'b0;
      restore_valid_q <= 1'b0;
      restore_pc_q <= 32'h0000_0000;
      restore_status_q <= 32'h0000_0000;
      exception_return_marker_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lr_load_q <= 1'b0;
      stk_push_q <= 1'b0;
      stk_pop_req_q <= is_fn_ret;
      restore_valid_q <= 1'b0;
      exception_return_marker_q <= is_exc_ret;
      if (br_valid && !chk_bad_tran && !chk_bad_entry) begin
        secure_state_q <= chk_next_secure;
      end
      if (br_valid && br_ns_call && secure_state_q && !chk_bad_tran) begin
        lr_load_q <= 1'b1;
        lr_value_q <= `STC_FNRET_MARKER;
        stk_push_q <= 1'b1;
        stk_push_addr_q <= br_return_addr;
        stk_push_status_q <= cur_status_word;
      end
      if (state_q == ST_POP && stk_pop_valid) begin
        restore_valid_q <= 1'b1;
        restore_pc_q <= stk_pop_pc;
        restore_status_q <= stk_pop_status;
        secure_state_q <= 1'b1;
      end
    end
  end

  // Flags and handler pulses. A handler fires in the cycle after any cause.
  always @(posedge clk_sys) begin
    if (reset) begin
      fault_take_q <= {`STC_NUM_H{1'b0}};
      severe_flags_q <= 2'h0;
      protect_flags_q <= 5'h00;
      bus_flags_q <= 6'h00;
      usage_flags_q <= 7'h00;
      secure_flags_q <= 7'h00;
    end else begin
      severe_flags_q <= sticky({5'h00, severe_flags_q}, {5'h00, sev_set},
        {5'h00, clr_severe})[1:0];
      protect_flags_q <= sticky({2'h0, protect_flags_q}, {2'h0, prot_set},
        {2'h0, clr_protect})[4:0];
      bus_flags_q <= sticky({1'b0, bus_flags_q}, {1'b0, bus_err},
        {1'b0, clr_bus})[5:0];
      usage_flags_q <= sticky(usage_flags_q, usage_err, clr_usage);
      secure_flags_q <= sticky(secure_flags_q, sec_set, clr_secure);
      fault_take_q[`STC_H_SEVERE] <= |sev_set;
      fault_take_q[`STC_H_PROTECT] <= |prot_set;
      fault_take_q[`STC_H_BUS] <= |bus_err;
      fault_take_q[`STC_H_USAGE] <= |usage_err;
      fault_take_q[`STC_H_SECURE] <= |sec_set;
    end
  end
endmodule
`default_nettype wire

// File: stc_defs.vh
/*
  Constants for the security transition and fault classifier: handler
  indices, flag positions within each status group, marker patterns and
  reset values. Assumes it is included by the classifier, its checker and its bench; the target check does not use it.
*/
// Functional notes
// - Secure to Non-secure needs NS branch or NS call, lsb clear.
// - Callable Secure target needs secure gateway instruction.
// - Non-callable Secure target from Non-secure always faults.
// - NS call loads marker, pushes return address, status.
// - Marker written to PC starts function return.
// - Function return restores PC and status from stack.
// - Any other change, including sequential crossing, faults.
// - Vector read bus error: severe handler, vector flag.
// - Escalated fault: severe handler, escalated flag.
// - Protection mismatch: protection handler, five cause flags.
// - Execute-never fetch sets instruction access flag always.
// - Bus errors: bus handler, six cause flags.
// - Coprocessor, undefined, state, return value: usage flags.
// - Unaligned, stack overflow, divide by zero: usage flags.
// - Security fault records cause in seven flags.
// - Top byte all ones marks exception return.
`ifndef STC_DEFS_VH
`define STC_DEFS_VH

// Handler indices on the fault take vector.
`define STC_H_SEVERE 0
`define STC_H_PROTECT 1
`define STC_H_BUS 2
`define STC_H_USAGE 3
`define STC_H_SECURE 4
`define STC_NUM_H 5

// Severe handler flags.
`define STC_HF_VECTOR 0
`define STC_HF_ESCAL 1
// Protection flags.
`define STC_MF_INSTR 0
`define STC_MF_DATA 1
`define STC_MF_STACK 2
`define STC_MF_UNSTACK 3
`define STC_MF_LAZYFP 4
// Bus error flags.
`define STC_BF_STACK 0
`define STC_BF_UNSTACK 1
`define STC_BF_PREFETCH 2
`define STC_BF_LAZYFP 3
`define STC_BF_EXACT 4
`define STC_BF_INEXACT 5
// Usage flags.
`define STC_UF_COPROC 0
`define STC_UF_UNDEF 1
`define STC_UF_STATE 2
`define STC_UF_RETVAL 3
`define STC_UF_UNALIGN 4
`define STC_UF_STKOVF 5
`define STC_UF_DIVZERO 6
// Security violation flags.
`define STC_SF_LAZYSTATE 0
`define STC_SF_LAZYPRES 1
`define STC_SF_INVALID_TRANSITION_FLAG 2
`define STC_SF_ATTRIB 3
`define STC_SF_EXCRET 4
`define STC_SF_INTEGRITY 5
`define STC_SF_ENTRY 6

// Exception return prefix lives in the top byte of the PC value.
`define STC_EXCRET_HI 31
`define STC_EXCRET_LO 24
`define STC_EXCRET_PREFIX 8'hff
// Neutral default for the function return marker.
`define STC_FNRET_MARKER 32'hfe00_0000
// State after reset: the core comes out of reset in Secure state.
`define STC_RST_SECURE 1'b1

`endif

// File: stc_target_check.v
/*
  Combinational legality check of one change of program flow between
  security states. Assumes the attribution lookup result and the gateway
  detection at the target are valid whenever the check is requested.
*/
`timescale 1ns/100ps
`default_nettype none
module stc_target_check (
  // Current state and target attribution
  input wire cur_secure,
  input wire tgt_secure,
  input wire tgt_callable,
  input wire tgt_lsb,
  input wire tgt_has_gateway,
  // Kind of flow change
  input wire is_ns_branch,
  input wire is_ns_call,
  input wire is_sequential,
  // Verdict
  output reg next_secure,
  output reg bad_transition,
  output reg bad_entry
);
  always @* begin
    next_secure = cur_secure;
    bad_transition = 1'b0;
    bad_entry = 1'b0;
    if (cur_secure && !tgt_secure) begin
      if (is_sequential) begin
        bad_transition = 1'b1;
      end else if ((is_ns_branch || is_ns_call) && !tgt_lsb) begin
        next_secure = 1'b0;
      end else begin
        bad_transition = 1'b1;
      end
    end else if (!cur_secure && tgt_secure) begin
      if (is_sequential) begin
        bad_transition = 1'b1;
      end else if (!tgt_callable) begin
        bad_transition = 1'b1;
      end else if (tgt_has_gateway) begin
        next_secure = 1'b1;
      end else begin
        bad_entry = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: stc_classifier_chk.sv
/* Assertions on the classifier ports, bound into every stc_classifier.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
`include "stc_defs.vh"
module stc_classifier_chk (
  // Clock, reset and causes
  input wire clk_sys,
  input wire reset,
  input wire br_valid,
  input wire br_sequential,
  input wire br_ns_branch,
  input wire br_ns_call,
  input wire [31:0] br_target,
  input wire br_tgt_secure,
  input wire br_tgt_callable,
  input wire br_tgt_gateway,
  input wire pcw_valid,
  input wire [31:0] pcw_value,
  input wire stk_pop_valid,
  input wire vec_read_bus_err,
  input wire xn_fetch,
  // Watched outputs
  input wire secure_state_q,
  input wire lr_load_q,
  input wire [31:0] lr_value_q,
  input wire stk_push_q,
  input wire stk_pop_req_q,
  input wire restore_valid_q,
  input wire exception_return_marker_q,
  input wire [4:0] fault_take_q,
  input wire [1:0] severe_flags_q,
  input wire [4:0] protect_flags_q,
  input wire [6:0] secure_flags_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire s_ns = br_valid && !br_sequential && secure_state_q && !br_tgt_secure;
  wire ns_s = br_valid && !br_sequential && !secure_state_q && br_tgt_secure;
  wire ok_sn = (br_ns_branch || br_ns_call) && !br_target[0];
  wire fn_hit = pcw_valid && !secure_state_q && pcw_value == `STC_FNRET_MARKER;
  wire flt_tran = fault_take_q[4] && secure_flags_q[2];
  wire flt_entry = fault_take_q[4] && secure_flags_q[6];
  sequence s_call; s_ns && br_ns_call && !br_target[0]; endsequence
  sequence s_push; !secure_state_q && lr_load_q && stk_push_q && lr_value_q == `STC_FNRET_MARKER; endsequence
  property p_call; s_call |=> s_push; endproperty
  a_call: assert property (p_call) else $error("Call sequence wrong.");
  property p_bad_sn; s_ns && !ok_sn |=> secure_state_q && flt_tran; endproperty
  a_bad_sn: assert property (p_bad_sn) else $error("Illegal exit passed.");
  property p_gw; ns_s && br_tgt_callable && br_tgt_gateway |=> secure_state_q; endproperty
  a_gw: assert property (p_gw) else $error("Gateway entry refused.");
  property p_no_gw; ns_s && br_tgt_callable && !br_tgt_gateway |=> !secure_state_q && flt_entry; endproperty
  a_no_gw: assert property (p_no_gw) else $error("Missing gateway passed.");
  property p_nocall; ns_s && !br_tgt_callable |=> !secure_state_q && flt_tran; endproperty
  a_nocall: assert property (p_nocall) else $error("Uncallable entry passed.");
  property p_seq; br_valid && br_sequential && secure_state_q != br_tgt_secure
    |=> $stable(secure_state_q) && flt_tran; endproperty
  a_seq: assert property (p_seq) else $error("Sequential crossing passed.");
  property p_pop; stk_pop_req_q |-> $past(fn_hit); endproperty
  a_pop: assert property (p_pop) else $error("Pop without marker.");
  property p_restore; restore_valid_q |-> secure_state_q && $past(stk_pop_valid); endproperty
  a_restore: assert property (p_restore) else $error("Restore wrong.");
  property p_exc; pcw_valid && pcw_value[31:24] == 8'hff |=> exception_return_marker_q && !stk_pop_req_q; endproperty
  a_exc: assert property (p_exc) else $error("Exception return missed.");
  property p_vec; vec_read_bus_err |=> fault_take_q[0] && severe_flags_q[0]; endproperty
  a_vec: assert property (p_vec) else $error("Vector error not severe.");
  property p_xn; xn_fetch |=> fault_take_q[1] && protect_flags_q[0]; endproperty
  a_xn: assert property (p_xn) else $error("Execute-never fetch missed.");
endmodule
bind stc_classifier stc_classifier_chk u_chk (.*);
`default_nettype wire

// File: stc_stack_model.sv
/* Secure stack behind the classifier: keeps the last pushed frame and
   answers a pop after a latency chosen by the bench. */
`timescale 1ns/100ps
`default_nettype none
module stc_stack_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Requests and latency
  input wire logic stk_push_q,
  input wire logic [31:0] stk_push_addr_q,
  input wire logic [31:0] stk_push_status_q,
  input wire logic stk_pop_req_q,
  input wire logic [2:0] lat,
  // Answer
  output logic stk_pop_valid,
  output logic [31:0] stk_pop_pc,
  output logic [31:0] stk_pop_status
);
  logic [63:0] frame_q;
  logic [3:0] wait_q;
  always @(posedge clk_sys) begin
    stk_pop_valid <= 1'b0;
    // Data toggles outside the answer so a stale capture cannot look right.
    {stk_pop_pc, stk_pop_status} <= ~{stk_pop_pc, stk_pop_status};
    if (stk_push_q) frame_q <= {stk_push_addr_q, stk_push_status_q};
    if (reset) begin
      wait_q <= 4'h0;
      frame_q <= 64'h0;
      {stk_pop_pc, stk_pop_status} <= 64'h0;
    end else if (stk_pop_req_q) begin
      wait_q <= {1'b0, lat} + 4'h1;
    end else if (wait_q == 4'h1) begin
      wait_q <= 4'h0;
      stk_pop_valid <= 1'b1;
      {stk_pop_pc, stk_pop_status} <= frame_q;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: test_stc_classifier.sv
/* Bench for stc_classifier: random flow changes, returns, every fault cause.
   Assumes the stack model answers pops and the checker is bound. */
`timescale 1ns/100ps
`default_nettype none
`include "stc_defs.vh"
module test_stc_classifier;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic br_valid = 1'b0;
  logic pcw_valid = 1'b0;
  logic [5:0] bf = 6'h0;
  logic [2:0] pk = 3'h1;
  logic [2:0] lat = 3'h0;
  logic [27:0] cause = 28'h0;
  logic [26:0] clr = 27'h0;
  logic [31:0] br_target = 32'h0, br_return_addr = 32'h0;
  logic [31:0] cur_status_word = 32'h0, pcw_value = 32'h0;
  wire br_sequential, br_ns_branch, br_ns_call, br_tgt_secure, br_tgt_callable;
  wire br_tgt_gateway, pcw_pop_multi, pcw_load, pcw_reg_branch, vec_read_bus_err;
  wire fault_escalated, xn_fetch, stk_pop_valid, secure_state_q, lr_load_q, stk_push_q;
  wire stk_pop_req_q, restore_valid_q, exception_return_marker_q;
  wire [1:0] clr_severe, severe_flags_q;
  wire [4:0] protect_mismatch, clr_protect, fault_take_q, protect_flags_q;
  wire [5:0] bus_err, clr_bus, bus_flags_q;
  wire [6:0] usage_err, secure_err, clr_usage, clr_secure, usage_flags_q, secure_flags_q;
  wire [31:0] stk_pop_pc, stk_pop_status, lr_value_q, stk_push_addr_q, stk_push_status_q;
  wire [31:0] restore_pc_q, restore_status_q;
  logic [72:0] exp_q[$];
  logic [72:0] obs;
  logic [63:0] frame = 64'h0;
  logic s_m = `STC_RST_SECURE;
  integer seed = 32'h173a440c;
  integer err_count = 0;
  integer checked = 0;
  integer cyc = 0;
  assign {br_sequential, br_ns_branch, br_ns_call, br_tgt_secure, br_tgt_callable,
    br_tgt_gateway} = bf;
  assign {pcw_pop_multi, pcw_load, pcw_reg_branch} = pk;
  assign {vec_read_bus_err, fault_escalated, protect_mismatch, xn_fetch, bus_err,
    usage_err, secure_err} = cause;
  assign {clr_severe, clr_protect, clr_bus, clr_usage, clr_secure} = clr;
  stc_classifier DUT (.*);
  stc_stack_model u_stack (.*);
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [72:0] seen, input logic [72:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t ns: got %h, want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic flow();
    logic [6:0] f;
    logic [63:0] fr;
    f = $random(seed);
    fr = {$random(seed), $random(seed)};
    // Branch kinds only make sense from Secure towards a Non-secure target.
    if (f[6] || !s_m || f[2]) f[5:4] = 2'b00;
    f[5] = f[5] & ~f[4];
    if (f[6]) f[2] = ~s_m;
    br_valid <= 1'b1;
    bf <= {f[6:4], f[2:0]};
    br_target <= {31'($random(seed)), f[3]};
    {br_return_addr, cur_status_word} <= fr;
    if (f[6] || (s_m && !f[2] && !((f[5] || f[4]) && !f[3])) || (!s_m && f[2] && !(f[1] && f[0])))
      exp_q.push_back({s_m, 5'h10, 67'h0});
    else if (s_m && !f[2]) begin
      s_m = 1'b0;
      if (f[4]) frame = fr;
      if (f[4]) exp_q.push_back({9'h002, `STC_FNRET_MARKER, 32'h0});
    end else if (!s_m && f[2]) s_m = 1'b1;
  endtask
  task automatic fret(input logic exc);
    integer i;
    br_valid <= 1'b0;
    pcw_valid <= 1'b1;
    pcw_value <= exc ? {8'hff, 24'($random(seed))} : `STC_FNRET_MARKER;
    pk <= 3'h1 << ({$random(seed)} % 3);
    lat <= $random(seed);
    if (exc) exp_q.push_back({s_m, 5'h0, 3'b100, 64'h0});
    else exp_q.push_back({9'h101, frame});
    s_m = s_m | ~exc;
    @(posedge clk_sys);
    pcw_valid <= 1'b0;
    for (i = 0; i < 12 && restore_valid_q !== 1'b1; i++) @(posedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (!reset && (|fault_take_q || exception_return_marker_q || lr_load_q || restore_valid_q)) begin
      obs = {secure_state_q, fault_take_q, exception_return_marker_q, lr_load_q, restore_valid_q,
        restore_valid_q ? {restore_pc_q, restore_status_q} : {lr_value_q, 32'h0}};
      if (!lr_load_q && !restore_valid_q) obs[63:0] = 64'h0;
      if (exp_q.size() == 0) chk(obs, ~obs);
      else chk(obs, exp_q.pop_front());
    end
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc > 5000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    for (int n = 1; n < 400; n++) begin
      @(posedge clk_sys);
      if (n % 16 == 0) fret(s_m || n % 48 == 0);
      else flow();
    end
    for (int i = 0; i < 28; i++) begin
      @(posedge clk_sys);
      br_valid <= 1'b0;
      cause <= 28'h1 << i;
      exp_q.push_back({s_m, i < 7 ? 5'h10 : i < 14 ? 5'h08 : i < 20 ? 5'h04 :
        i < 26 ? 5'h02 : 5'h01, 67'h0});
    end
    @(posedge clk_sys);
    cause <= 28'h0;
    repeat (2) @(posedge clk_sys);
    #1 chk({severe_flags_q, protect_flags_q, bus_flags_q, usage_flags_q, secure_flags_q},
      {27{1'b1}});
    @(posedge clk_sys);
    clr <= {27{1'b1}};
    @(posedge clk_sys);
    clr <= 27'h0;
    @(posedge clk_sys);
    #1 chk({severe_flags_q, protect_flags_q, bus_flags_q, usage_flags_q, secure_flags_q},
      27'h0);
    chk(exp_q.size() == 0, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
